// ===== pkg/tmr8_pkg.sv
// constants shared by the 8-bit timer with shared prescaler
package tmr8_pkg;

	// register byte offsets on the AXI4-Lite bus
	localparam logic [7:0] OFS_COUNT = 8'h00;
	localparam logic [7:0] OFS_OPTION = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_WDCLR = 8'h0C;

	// option register fields
	localparam int OPT_CS_BIT = 5;
	localparam int OPT_SE_BIT = 4;
	localparam int OPT_PA_BIT = 3;
	localparam int OPT_RATE_LSB = 0;
	localparam int OPT_RATE_W = 3;
	localparam logic [5:0] OPTION_RST = 6'h3F;

	// status register fields
	localparam int STAT_OVF_BIT = 0;
	localparam int STAT_OIE_BIT = 1;
	localparam logic [1:0] STATUS_RST = 2'h0;

	// watchdog clear register field
	localparam int WDCLR_BIT = 0;

	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [7:0] COUNT_MAX = 8'hFF;

	// one instruction cycle is four system clocks
	localparam int INSTR_CLKS = 4;
	localparam logic [1:0] INSTR_LAST = 2'(INSTR_CLKS - 1);
	// increment hold-off after a count write, in instruction cycles
	localparam logic [1:0] WR_INHIBIT_CYC = 2'h2;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : tmr8_pkg

// ===== hw/tmr8_edge.sv
// selectable edge detector for the external count input
`timescale 1ns/1ps
module tmr8_edge (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_pin,
	input wire logic i_fall_sel,
	output logic o_evt
);
	logic prev_q;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= i_pin;
		end
	end

	// high-to-low when the select is set, low-to-high otherwise
	assign o_evt = i_fall_sel ? (prev_q & ~i_pin) : (~prev_q & i_pin);

endmodule : tmr8_edge

// ===== hw/tmr8_presc.sv
// 8-bit ripple-free prescaler, divide ratio given as a mask of low bits
`timescale 1ns/1ps
module tmr8_presc (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_tick,
	input wire logic i_clr,
	input wire logic [7:0] i_mask,
	output logic o_tick
);
	logic [7:0] cnt_q;
	logic wrap;

	assign wrap = ((cnt_q & i_mask) == i_mask);
	assign o_tick = i_tick & wrap;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_q <= 8'h00;
		end else if (i_clr) begin
			cnt_q <= 8'h00;
		end else if (i_tick) begin
			cnt_q <= wrap ? 8'h00 : cnt_q + 8'h01;
		end
	end

endmodule : tmr8_presc

// ===== hw/tmr8_top.sv
// 8-bit timer/counter with prescaler shared with the watchdog, AXI4-Lite registers
// Operation
// - 8-bit count and one shared 8-bit prescaler
// - timer mode counts each instruction cycle
// - count write holds increments two instruction cycles
// - counter mode counts chosen external input edges
// - single prescaler serves timer or watchdog only
// - assign bit 0 timer, 1 watchdog
// - timer ratios 1:2 to 1:256 by rate
// - undivided timer only when prescaler on watchdog
// - prescaler count hidden from software entirely
// - count write clears prescaler when on timer
// - watchdog clear also clears prescaler when assigned
// - wrap FFh to 00h sets sticky overflow flag
// - rate codes map powers of two both users
// - edge select 1 falling, 0 rising
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module tmr8_top (
	input wire logic I_MCLK,
	input wire logic I_SRST,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [7:0] I_AWADDR,
	input wire logic I_WVALID,
	output logic O_WREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	output logic O_BVALID,
	input wire logic I_BREADY,
	output logic [1:0] O_BRESP,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	input wire logic [7:0] I_ARADDR,
	output logic O_RVALID,
	input wire logic I_RREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	input wire logic I_EXTERNAL_COUNT_INPUT,
	input wire logic I_WATCHDOG_BASE_TICK,
	output logic O_WATCHDOG_TICK,
	output logic O_WATCHDOG_CLEAR,
	output logic O_OVERFLOW_FLAG,
	output logic [7:0] O_TIMER8_COUNT
);

	// register state
	logic [7:0] timer8_count_q;
	logic clock_source_select_q;
	logic source_edge_select_q;
	logic prescaler_assign_q;
	logic [2:0] prescale_rate_q;
	logic overflow_flag_q;
	logic overflow_interrupt_enable_q;

	// instruction cycle divider and write hold-off
	logic [1:0] instr_cnt_q;
	logic instr_en_q;
	logic [1:0] inhibit_q;

	// AXI write channel state
	logic aw_full_q;
	logic aw_full_d;
	logic [7:0] aw_addr_q;
	logic w_full_q;
	logic w_full_d;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic awready_q;
	logic wready_q;
	logic bvalid_q;
	logic [1:0] bresp_q;

	// AXI read channel state
	logic arready_q;
	logic rvalid_q;
	logic rvalid_d;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	logic wdt_tick_q;
	logic wdt_clear_q;

	// datapath nets
	logic wr_commit;
	logic wr_lane0;
	logic wr_count;
	logic wr_option;
	logic wr_status;
	logic wr_wdclr;
	logic wr_hit;
	logic ar_take;
	logic [31:0] rd_word;
	logic rd_hit;
	logic ext_evt;
	logic src_tick;
	logic presc_in;
	logic presc_out;
	logic presc_clr;
	logic [7:0] presc_mask;
	logic count_inc;
	logic ovf_set;
	logic ovf_clr;

	// instruction cycle enable: one pulse every four system clocks
	always_ff @(posedge I_MCLK) begin
		if (I_SRST) begin
			instr_cnt_q <= 2'h0;
			instr_en_q <= 1'b0;
		end else begin
			instr_cnt_q <= (instr_cnt_q == tmr8_pkg::INSTR_LAST) ? 2'h0 : instr_cnt_q + 2'h1;
			instr_en_q <= (instr_cnt_q == tmr8_pkg::INSTR_LAST);
		end
	end

	// AXI write: address and data taken in either order, committed together
	assign wr_commit = aw_full_q & w_full_q & ~bvalid_q;
	assign wr_lane0 = w_strb_q[0];
	assign wr_count = wr_commit & wr_lane0 & (aw_addr_q == tmr8_pkg::OFS_COUNT);
	assign wr_option = wr_commit & wr_lane0 & (aw_addr_q == tmr8_pkg::OFS_OPTION);
	assign wr_status = wr_commit & wr_lane0 & (aw_addr_q == tmr8_pkg::OFS_STATUS);
	assign wr_wdclr = wr_commit & wr_lane0 & (aw_addr_q == tmr8_pkg::OFS_WDCLR);
	assign wr_hit = (aw_addr_q == tmr8_pkg::OFS_COUNT) | (aw_addr_q == tmr8_pkg::OFS_OPTION) |
		(aw_addr_q == tmr8_pkg::OFS_STATUS) | (aw_addr_q == tmr8_pkg::OFS_WDCLR);

	always_comb begin
		aw_full_d = aw_full_q;
		w_full_d = w_full_q;
		if (wr_commit) begin
			aw_full_d = 1'b0;
			w_full_d = 1'b0;
		end else begin
			if (I_AWVALID & awready_q) begin
				aw_full_d = 1'b1;
			end
			if (I_WVALID & wready_q) begin
				w_full_d = 1'b1;
			end
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (I_SRST) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
		end else begin
			aw_full_q <= aw_full_d;
			w_full_q <= w_full_d;
			awready_q <= ~aw_full_d;
			wready_q <= ~w_full_d;
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (I_SRST) begin
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else begin
			if (I_AWVALID & awready_q) begin
				aw_addr_q <= {I_AWADDR[7:2], 2'b00};
			end
			if (I_WVALID & wready_q) begin
				w_data_q <= I_WDATA;
				w_strb_q <= I_WSTRB;
			end
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (I_SRST) begin
			bvalid_q <= 1'b0;
			bresp_q <= tmr8_pkg::RESP_OKAY;
		end else if (wr_commit) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_hit ? tmr8_pkg::RESP_OKAY : tmr8_pkg::RESP_SLVERR;
		end else if (bvalid_q & I_BREADY) begin
			bvalid_q <= 1'b0;
		end
	end

	// AXI read: one outstanding read, data registered with the valid
	assign ar_take = I_ARVALID & arready_q;

	// the prescaler count has no address: it cannot be read or written
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit = 1'b1;
		case ({I_ARADDR[7:2], 2'b00})
			tmr8_pkg::OFS_COUNT: begin
				rd_word[7:0] = timer8_count_q;
			end
			tmr8_pkg::OFS_OPTION: begin
				rd_word[tmr8_pkg::OPT_CS_BIT] = clock_source_select_q;
				rd_word[tmr8_pkg::OPT_SE_BIT] = source_edge_select_q;
				rd_word[tmr8_pkg::OPT_PA_BIT] = prescaler_assign_q;
				rd_word[tmr8_pkg::OPT_RATE_LSB +: tmr8_pkg::OPT_RATE_W] = prescale_rate_q;
			end
			tmr8_pkg::OFS_STATUS: begin
				rd_word[tmr8_pkg::STAT_OVF_BIT] = overflow_flag_q;
				rd_word[tmr8_pkg::STAT_OIE_BIT] = overflow_interrupt_enable_q;
			end
			tmr8_pkg::OFS_WDCLR: begin
				rd_word = 32'h0000_0000;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	always_comb begin
		rvalid_d = rvalid_q;
		if (ar_take) begin
			rvalid_d = 1'b1;
		end else if (rvalid_q & I_RREADY) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (I_SRST) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= tmr8_pkg::RESP_OKAY;
		end else begin
			rvalid_q <= rvalid_d;
			arready_q <= ~rvalid_d;
			if (ar_take) begin
				rdata_q <= rd_word;
				rresp_q <= rd_hit ? tmr8_pkg::RESP_OKAY : tmr8_pkg::RESP_SLVERR;
			end
		end
	end

	// option register; the move order between timer and watchdog is software's duty
	always_ff @(posedge I_MCLK) begin
		if (I_SRST) begin
			clock_source_select_q <= tmr8_pkg::OPTION_RST[tmr8_pkg::OPT_CS_BIT];
			source_edge_select_q <= tmr8_pkg::OPTION_RST[tmr8_pkg::OPT_SE_BIT];
			prescaler_assign_q <= tmr8_pkg::OPTION_RST[tmr8_pkg::OPT_PA_BIT];
			prescale_rate_q <= tmr8_pkg::OPTION_RST[tmr8_pkg::OPT_RATE_LSB +: tmr8_pkg::OPT_RATE_W];
		end else if (wr_option) begin
			clock_source_select_q <= w_data_q[tmr8_pkg::OPT_CS_BIT];
			source_edge_select_q <= w_data_q[tmr8_pkg::OPT_SE_BIT];
			prescaler_assign_q <= w_data_q[tmr8_pkg::OPT_PA_BIT];
			prescale_rate_q <= w_data_q[tmr8_pkg::OPT_RATE_LSB +: tmr8_pkg::OPT_RATE_W];
		end
	end

	// external count input edges
	tmr8_edge u_edge (
		.i_clk(I_MCLK),
		.i_rst(I_SRST),
		.i_pin(I_EXTERNAL_COUNT_INPUT),
		.i_fall_sel(source_edge_select_q),
		.o_evt(ext_evt)
	);

	// count source: instruction cycle or external edge
	assign src_tick = clock_source_select_q ? ext_evt : instr_en_q;

	// one prescaler, steered to exactly one user
	assign presc_in = prescaler_assign_q ? I_WATCHDOG_BASE_TICK : src_tick;
	// timer sees 1:2..1:256, watchdog 1:1..1:128
	assign presc_mask = prescaler_assign_q ? 8'((9'h001 << prescale_rate_q) - 9'h001) :
		8'((9'h002 << prescale_rate_q) - 9'h001);
	// count write clears it while on the timer, watchdog clear while on the watchdog
	assign presc_clr = prescaler_assign_q ? wr_wdclr & w_data_q[tmr8_pkg::WDCLR_BIT] : wr_count;

	tmr8_presc u_presc (
		.i_clk(I_MCLK),
		.i_rst(I_SRST),
		.i_tick(presc_in),
		.i_clr(presc_clr),
		.i_mask(presc_mask),
		.o_tick(presc_out)
	);

	// undivided timer only when the prescaler belongs to the watchdog
	assign count_inc = (prescaler_assign_q ? src_tick : presc_out) & (inhibit_q == 2'h0);

	// hold-off counts instruction cycles after each count write
	always_ff @(posedge I_MCLK) begin
		if (I_SRST) begin
			inhibit_q <= 2'h0;
		end else if (wr_count) begin
			inhibit_q <= tmr8_pkg::WR_INHIBIT_CYC;
		end else if (instr_en_q & (inhibit_q != 2'h0)) begin
			inhibit_q <= inhibit_q - 2'h1;
		end
	end

	// count register; a software write wins over an increment in the same cycle
	always_ff @(posedge I_MCLK) begin
		if (I_SRST) begin
			timer8_count_q <= tmr8_pkg::COUNT_RST;
		end else if (wr_count) begin
			timer8_count_q <= w_data_q[7:0];
		end else if (count_inc) begin
			timer8_count_q <= timer8_count_q + 8'h01;
		end
	end

	// overflow flag is sticky and set regardless of its enable
	assign ovf_set = count_inc & ~wr_count & (timer8_count_q == tmr8_pkg::COUNT_MAX);
	assign ovf_clr = wr_status & w_data_q[tmr8_pkg::STAT_OVF_BIT];

	always_ff @(posedge I_MCLK) begin
		if (I_SRST) begin
			overflow_flag_q <= tmr8_pkg::STATUS_RST[tmr8_pkg::STAT_OVF_BIT];
		end else if (ovf_set) begin
			overflow_flag_q <= 1'b1;
		end else if (ovf_clr) begin
			overflow_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (I_SRST) begin
			overflow_interrupt_enable_q <= tmr8_pkg::STATUS_RST[tmr8_pkg::STAT_OIE_BIT];
		end else if (wr_status) begin
			overflow_interrupt_enable_q <= w_data_q[tmr8_pkg::STAT_OIE_BIT];
		end
	end

	// watchdog side: divided tick out and clear pulse out
	always_ff @(posedge I_MCLK) begin
		if (I_SRST) begin
			wdt_tick_q <= 1'b0;
			wdt_clear_q <= 1'b0;
		end else begin
			wdt_tick_q <= prescaler_assign_q & presc_out;
			wdt_clear_q <= wr_wdclr & w_data_q[tmr8_pkg::WDCLR_BIT];
		end
	end

	assign O_AWREADY = awready_q;
	assign O_WREADY = wready_q;
	assign O_BVALID = bvalid_q;
	assign O_BRESP = bresp_q;
	assign O_ARREADY = arready_q;
	assign O_RVALID = rvalid_q;
	assign O_RDATA = rdata_q;
	assign O_RRESP = rresp_q;
	assign O_WATCHDOG_TICK = wdt_tick_q;
	assign O_WATCHDOG_CLEAR = wdt_clear_q;
	assign O_OVERFLOW_FLAG = overflow_flag_q;
	assign O_TIMER8_COUNT = timer8_count_q;

endmodule : tmr8_top

// ===== verification/tmr8_sva.sv
// port-level timing checks for the 8-bit timer block
`timescale 1ns/1ps
module tmr8_sva (
	input wire logic I_MCLK,
	input wire logic I_SRST,
	input wire logic I_AWVALID,
	input wire logic O_AWREADY,
	input wire logic [7:0] I_AWADDR,
	input wire logic I_WVALID,
	input wire logic O_WREADY,
	input wire logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic [1:0] O_BRESP,
	input wire logic I_ARVALID,
	input wire logic O_ARREADY,
	input wire logic O_RVALID,
	input wire logic I_RREADY,
	input wire logic [31:0] O_RDATA,
	input wire logic O_WATCHDOG_CLEAR,
	input wire logic O_OVERFLOW_FLAG,
	input wire logic [7:0] O_TIMER8_COUNT
);
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (I_SRST);
	logic [7:0] wa_q;
	// remembers which register the pending write targets
	always_ff @(posedge I_MCLK) begin
		if (I_SRST) wa_q <= 8'h00;
		else if (I_AWVALID && O_AWREADY) wa_q <= I_AWADDR;
	end
	sequence s_wrap;
		O_TIMER8_COUNT == 8'hFF ##1 (O_TIMER8_COUNT == 8'h00 && !$rose(O_BVALID));
	endsequence
	sequence s_both;
		I_AWVALID && O_AWREADY && I_WVALID && O_WREADY && !O_BVALID;
	endsequence
	a_wrap_sets_flag: assert property (s_wrap |-> O_OVERFLOW_FLAG)
		else $error("flag not set on wrap");
	a_flag_sticky: assert property ($fell(O_OVERFLOW_FLAG) |-> $rose(O_BVALID))
		else $error("flag cleared without a write");
	a_count_step: assert property (!$rose(O_BVALID) |->
		O_TIMER8_COUNT == $past(O_TIMER8_COUNT) || O_TIMER8_COUNT == $past(O_TIMER8_COUNT) + 8'h01)
		else $error("count jumped");
	a_write_holdoff: assert property ($rose(O_BVALID) && wa_q[7:2] == 6'h00 |=>
		$stable(O_TIMER8_COUNT) [*4]) else $error("count moved right after write");
	a_write_lat: assert property (s_both |=> !O_AWREADY ##1 O_BVALID) else $error("write answer late");
	a_b_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
		else $error("write response dropped");
	a_read_lat: assert property (I_ARVALID && O_ARREADY |=> O_RVALID) else $error("read answer late");
	a_r_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
		else $error("read data dropped");
	a_clr_pulse: assert property (O_WATCHDOG_CLEAR |=> !O_WATCHDOG_CLEAR)
		else $error("watchdog clear too long");
endmodule : tmr8_sva
bind tmr8_top tmr8_sva u_sva (.I_MCLK, .I_SRST, .I_AWVALID, .O_AWREADY, .I_AWADDR, .I_WVALID, .O_WREADY,
	.O_BVALID, .I_BREADY, .O_BRESP, .I_ARVALID, .O_ARREADY, .O_RVALID, .I_RREADY, .O_RDATA,
	.O_WATCHDOG_CLEAR, .O_OVERFLOW_FLAG, .O_TIMER8_COUNT);

// ===== verification/tmr8_far_model.sv
// far-side stand-in: toggles the count pin and supplies the watchdog base tick
`timescale 1ns/1ps
module tmr8_far_model (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_go,
	input wire logic i_slow,
	input wire logic [7:0] i_toggles,
	output logic o_pin,
	output logic o_base_tick
);
	logic [7:0] left_q;
	logic [2:0] div_q;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			div_q <= 3'h0;
			o_base_tick <= 1'b0;
		end else begin
			div_q <= div_q + 3'h1;
			o_base_tick <= div_q == 3'h7;
		end
	end
	// fast mode toggles every second clock, slow mode every eighth clock
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			left_q <= 8'h00;
			o_pin <= 1'b0;
		end else if (i_go) begin
			left_q <= i_toggles;
		end else if (left_q != 8'h00 && (i_slow ? div_q == 3'h0 : div_q[0])) begin
			left_q <= left_q - 8'h01;
			o_pin <= !o_pin;
		end
	end
endmodule : tmr8_far_model

// ===== verification/testbench.sv
// self-checking bench for the 8-bit timer with shared prescaler
`timescale 1ns/1ps
module testbench;
	logic I_MCLK, I_SRST, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY, go, slow, p;
	logic [7:0] I_AWADDR, I_ARADDR, tog, dc;
	logic [31:0] I_WDATA, O_RDATA, d;
	logic [3:0] I_WSTRB;
	logic I_EXTERNAL_COUNT_INPUT, I_WATCHDOG_BASE_TICK, O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
	logic O_WATCHDOG_TICK, O_WATCHDOG_CLEAR, O_OVERFLOW_FLAG;
	logic [1:0] O_BRESP, O_RRESP, rs;
	logic [7:0] O_TIMER8_COUNT;
	int fail_count, checks, tn, cyc, wdt, clrs, dw, r, n;
	tmr8_top dut (.I_MCLK, .I_SRST, .I_AWVALID, .O_AWREADY, .I_AWADDR, .I_WVALID, .O_WREADY, .I_WDATA, .I_WSTRB,
		.O_BVALID, .I_BREADY, .O_BRESP, .I_ARVALID, .O_ARREADY, .I_ARADDR, .O_RVALID, .I_RREADY, .O_RDATA,
		.O_RRESP, .I_EXTERNAL_COUNT_INPUT, .I_WATCHDOG_BASE_TICK, .O_WATCHDOG_TICK, .O_WATCHDOG_CLEAR,
		.O_OVERFLOW_FLAG, .O_TIMER8_COUNT);
	tmr8_far_model far (.i_clk(I_MCLK), .i_rst(I_SRST), .i_go(go), .i_slow(slow), .i_toggles(tog),
		.o_pin(I_EXTERNAL_COUNT_INPUT), .o_base_tick(I_WATCHDOG_BASE_TICK));
	initial begin
		I_MCLK = 1'b0;
		forever #10 I_MCLK = ~I_MCLK;
	end
	always @(posedge I_MCLK) begin
		wdt <= wdt + O_WATCHDOG_TICK;
		clrs <= clrs + O_WATCHDOG_CLEAR;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fail_count++;
			results();
		end
	end
	function automatic int f_edges(int k, bit fall, bit lvl);
		return (fall == lvl) ? (k + 1) / 2 : k / 2;
	endfunction : f_edges
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: exp %h got %h", $time, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		bit ta, tw;
		ta = 0;
		tw = 0;
		I_AWADDR <= a;
		I_WDATA <= v;
		I_AWVALID <= 1'b1;
		I_WVALID <= 1'b1;
		while (!(ta && tw)) begin
			@(posedge I_MCLK);
			ta |= O_AWREADY;
			tw |= O_WREADY;
			I_AWVALID <= !ta;
			I_WVALID <= !tw;
		end
		repeat ($urandom_range(2)) @(posedge I_MCLK);
		I_BREADY <= 1'b1;
		do @(posedge I_MCLK); while (O_BVALID !== 1'b1);
		chk({30'h0, tmr8_pkg::RESP_OKAY}, {30'h0, O_BRESP});
		I_BREADY <= 1'b0;
		@(posedge I_MCLK);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		I_ARADDR <= a;
		I_ARVALID <= 1'b1;
		do @(posedge I_MCLK); while (O_ARREADY !== 1'b1);
		I_ARVALID <= 1'b0;
		repeat ($urandom_range(2)) @(posedge I_MCLK);
		I_RREADY <= 1'b1;
		do @(posedge I_MCLK); while (O_RVALID !== 1'b1);
		d = O_RDATA;
		rs = O_RRESP;
		I_RREADY <= 1'b0;
		@(posedge I_MCLK);
	endtask : rd
	task automatic span(input int k);
		logic [7:0] c;
		int w;
		c = O_TIMER8_COUNT;
		w = wdt;
		repeat (k) @(posedge I_MCLK);
		dc = O_TIMER8_COUNT - c;
		dw = wdt - w;
	endtask : span
	task automatic fin;
		tn++;
		$display("test %0d done", tn);
	endtask : fin
	task results;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : results
	initial begin
		{I_SRST, I_WSTRB} = 5'h1F;
		{I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY, go, slow} = 7'h00;
		{I_AWADDR, I_ARADDR, I_WDATA, tog} = 56'h0;
		{fail_count, checks, tn, cyc, wdt, clrs} = '0;
		void'($urandom(32'hB1449A65));
		repeat (12) @(posedge I_MCLK);
		I_SRST <= 1'b0;
		@(posedge I_MCLK);
		rd(tmr8_pkg::OFS_OPTION);
		chk({26'h0, tmr8_pkg::OPTION_RST}, d);
		rd(8'h10);
		chk({30'h0, tmr8_pkg::RESP_SLVERR}, {30'h0, rs});
		chk(32'h0, d);
		fin();
		wr(tmr8_pkg::OFS_OPTION, 32'h08);
		span(64);
		chk(32'd16, {24'h0, dc});
		for (r = 0; r < 8; r++) begin
			wr(tmr8_pkg::OFS_OPTION, r);
			repeat (4 << (r + 1)) @(posedge I_MCLK);
			span(8 << (r + 1));
			chk(32'd2, {24'h0, dc});
			chk(32'd0, dw);
		end
		fin();
		repeat (3) begin
			r = $urandom_range(7);
			wr(tmr8_pkg::OFS_OPTION, 32'h08 | r);
			repeat (8 << r) @(posedge I_MCLK);
			span(16 << r);
			chk(32'd2, dw);
		end
		wr(tmr8_pkg::OFS_OPTION, 32'h07);
		wr(tmr8_pkg::OFS_WDCLR, 32'h1);
		wr(tmr8_pkg::OFS_COUNT, 32'h0);
		wr(tmr8_pkg::OFS_OPTION, 32'h0F);
		// let the prescaler fill up so that a missing clear would give a tick below
		repeat (600) @(posedge I_MCLK);
		n = clrs;
		wr(tmr8_pkg::OFS_WDCLR, 32'h1);
		chk(32'd1, clrs - n);
		span(900);
		chk(32'd0, dw);
		fin();
		wr(tmr8_pkg::OFS_WDCLR, 32'h1);
		wr(tmr8_pkg::OFS_OPTION, 32'h07);
		repeat (700) @(posedge I_MCLK);
		wr(tmr8_pkg::OFS_COUNT, 32'h55);
		repeat (900) @(posedge I_MCLK);
		chk(32'h55, {24'h0, O_TIMER8_COUNT});
		wr(tmr8_pkg::OFS_OPTION, 32'h08);
		// earlier wraps left the flag set; start the overflow test from a clear flag
		wr(tmr8_pkg::OFS_STATUS, 32'h1);
		chk(32'h0, {31'h0, O_OVERFLOW_FLAG});
		wr(tmr8_pkg::OFS_COUNT, 32'hFA + $urandom_range(4));
		repeat (64) @(posedge I_MCLK);
		rd(tmr8_pkg::OFS_STATUS);
		chk(32'h1, d);
		wr(tmr8_pkg::OFS_STATUS, 32'h1);
		chk(32'h0, {31'h0, O_OVERFLOW_FLAG});
		fin();
		for (r = 0; r < 4; r++) begin
			wr(tmr8_pkg::OFS_OPTION, r[0] ? 32'h38 : 32'h28);
			n = $urandom_range(30, 1);
			p = I_EXTERNAL_COUNT_INPUT;
			tog <= 8'(n);
			slow <= r[1];
			go <= 1'b1;
			@(posedge I_MCLK);
			go <= 1'b0;
			span(n * 8 + 8);
			chk(f_edges(n, r[0], p), {24'h0, dc});
		end
		fin();
		results();
	end
endmodule : testbench
